// [smc_pkg.sv]
// Constants and types for the core supply mode control block
`default_nettype none
package smc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  ADDR_VSEL      = 8'h3a;
	localparam logic [7:0]  ADDR_BYP       = 8'h3b;
	localparam logic [3:0]  CODE_RST       = 4'h0;
	localparam logic        BYP_RST        = 1'b0;
	localparam int          VSEL_RO_LSB    = 4;
	localparam int          BYP_RO_LSB     = 4;
	localparam int          BYP_EN_BIT     = 0;
	// ****************************************
	// Capability identifier byte
	// ****************************************
	localparam int          CAP_VPS_BIT    = 7;
	localparam int          CAP_LV_BIT     = 4;
	localparam int          CAP_BYP_BIT    = 3;
	// ****************************************
	// Voltage scale, one count is 100 uV
	// ****************************************
	localparam logic [15:0] NOM_CNT        = 16'h4650;
	localparam logic [15:0] STEP_CNT       = 16'h03e8;
	localparam logic [15:0] TOL_CNT_RST    = 16'h0384;
	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_NS         = 10;
	localparam int          SETTLE_NS      = 1000;
	localparam int          SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          SETTLE_W       = 8;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		SMC_MODE_DEFAULT = 2'h0,
		SMC_MODE_LV      = 2'h1,
		SMC_MODE_BYPASS  = 2'h2
	} smc_mode_t;
	typedef enum logic [1:0] {
		SMC_ST_RUN     = 2'h0,
		SMC_ST_STANDBY = 2'h1,
		SMC_ST_CHECK   = 2'h3,
		SMC_ST_FAULT   = 2'h2
	} smc_state_t;
endpackage
`default_nettype wire

// [smc_thr_if.sv]
// Link between mode control and the supply threshold checker
`default_nettype none
interface smc_thr_if;
	logic [3:0]           code;
	logic [3:0]           byp_code;
	smc_pkg::smc_mode_t   mode;
	logic [15:0]          tol;
	logic [15:0]          meas;
	logic                 meas_valid;
	logic [15:0]          thr_lo;
	logic [15:0]          thr_hi;
	logic                 below;
	logic                 above;
	logic                 seen;
	modport ctl (output code, byp_code, mode, tol, meas, meas_valid,
		input thr_lo, thr_hi, below, above, seen);
	modport chk (input code, byp_code, mode, tol, meas, meas_valid,
		output thr_lo, thr_hi, below, above, seen);
endinterface
`default_nettype wire

// [smc_thr_check.sv]
// Mode dependent supply thresholds and range comparison
`default_nettype none
module smc_thr_check (
	input  wire logic i_clk,
	input  wire logic i_rst,
	smc_thr_if.chk    thr
);
	logic [15:0] nom;
	logic [15:0] lo_d;
	logic [15:0] hi_d;
	logic [15:0] meas_q;
	logic [15:0] lo_q;
	logic [15:0] hi_q;
	logic        seen_q;
	// ****************************************
	// Threshold derivation
	// ****************************************
	// R6 code to voltage
	assign nom  = (thr.mode == smc_pkg::SMC_MODE_LV) ?
		16'(smc_pkg::NOM_CNT - 16'(thr.code) * smc_pkg::STEP_CNT) :
		(thr.mode == smc_pkg::SMC_MODE_BYPASS) ?
		16'(smc_pkg::NOM_CNT - 16'(thr.byp_code) * smc_pkg::STEP_CNT) : smc_pkg::NOM_CNT;
	// R8 thresholds follow mode
	assign lo_d = (nom > thr.tol) ? 16'(nom - thr.tol) : 16'h0000;
	assign hi_d = 16'(nom + thr.tol);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meas_q <= 16'h0000;
			seen_q <= 1'b0;
			lo_q   <= 16'h0000;
			hi_q   <= 16'hffff;
		end else begin
			lo_q <= lo_d;
			hi_q <= hi_d;
			// R7 core rail sampled
			if (thr.meas_valid) begin
				meas_q <= thr.meas;
				seen_q <= 1'b1;
			end
		end
	end
	assign thr.thr_lo = lo_q;
	assign thr.thr_hi = hi_q;
	assign thr.seen   = seen_q;
	assign thr.below  = seen_q && (meas_q < lo_q);
	assign thr.above  = seen_q && (meas_q > hi_q);
endmodule
`default_nettype wire

// [smc_supply_mode_control.sv]
// Core supply mode registers, standby sequencing and supply monitor
// Operation
// R1 - Power up in default 1.8 V mode
// R2 - Writable voltage code nibble, resets zero
// R3 - Read-only lowest regulated voltage code nibble
// R4 - Read-only bypassed voltage code nibble
// R5 - Bypass enable bit zero, reserved bits
// R6 - Code maps to nominal minus code*100mV
// R7 - Optional modes monitor the core rail
// R8 - Thresholds adjust to selected mode
// R9 - Interrupt when core supply out of range
// R10 - Host changes settings only in standby
// R11 - Register access works during changes
// R12 - Power-down edge keeps written mode fields
// R13 - Host holds power-down on empty sockets
// R14 - Standby via power-down, transmitter disabled
// R15 - Host reads bytes, writes code in standby
// R16 - Leaving standby checks supply, flags fault
// R17 - Bypass entry writes enable bit instead
// R18 - Default return restores writable fields
// R19 - Code over bypass when both nonzero
// R20 - Capability bit 7 reports supply control
// R21 - Bits 4 and 3 report each mode
// R22 - Unsupported device reads all zeros
// R23 - Supply flags latch until cleared
// R24 - Read-only and reserved writes ignored
`default_nettype none
module smc_supply_mode_control #(
	parameter bit          SUPPORT_LV     = 1'b1,
	parameter bit          SUPPORT_BYPASS = 1'b1,
	parameter logic [3:0]  LV_MIN_CODE    = 4'h3,
	parameter logic [3:0]  BYP_CODE       = 4'h6,
	parameter logic [15:0] TOL_CNT        = smc_pkg::TOL_CNT_RST
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_p_down,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic [15:0] i_vcc_meas,
	input  wire logic        i_vcc_meas_valid,
	input  wire logic        i_flag_clr,
	output logic      [7:0]  o_reg_rdata,
	output logic      [7:0]  o_cap_id,
	output logic      [1:0]  o_mode,
	output logic             o_tx_disable,
	output logic             o_module_not_ready,
	output logic             o_vcc_flag_lo,
	output logic             o_vcc_flag_hi,
	output logic             o_int,
	output logic      [15:0] o_thr_lo,
	output logic      [15:0] o_thr_hi
);
	// ****************************************
	// Declarations
	// ****************************************
	localparam bit ANY_OPT = SUPPORT_LV || SUPPORT_BYPASS;
	localparam int SMC_SW = smc_pkg::SETTLE_W;
	localparam logic [SMC_SW-1:0] SETTLE_LAST = SMC_SW'(smc_pkg::SETTLE_CYC - 1);
	smc_thr_if thr ();
	smc_pkg::smc_state_t state_q;
	smc_pkg::smc_state_t state_d;
	smc_pkg::smc_mode_t  mode_q;
	smc_pkg::smc_mode_t  mode_d;
	logic                 pd_s1_q;
	logic                 pd_s2_q;
	logic [3:0]           code_q;
	logic                 byp_q;
	logic [7:0]           rdata_q;
	logic [7:0]           rd_d;
	logic [7:0]           vsel_rd;
	logic [7:0]           byp_rd;
	logic                 wr_vsel;
	logic                 wr_byp;
	logic [SMC_SW-1:0]    settle_q;
	logic                 settle_done;
	logic                 check_bad;
	logic                 run_bad_lo;
	logic                 run_bad_hi;
	logic                 set_lo;
	logic                 set_hi;
	logic                 flag_lo_q;
	logic                 flag_hi_q;
	logic                 int_q;
	logic                 txd_q;
	logic                 nr_q;

	// ****************************************
	// Power-down pin synchroniser
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pd_s1_q <= 1'b0;
			pd_s2_q <= 1'b0;
		end else begin
			pd_s1_q <= i_p_down;
			pd_s2_q <= pd_s1_q;
		end
	end

	// ****************************************
	// Register port
	// ****************************************
	// R11 decode never gated by state
	assign wr_vsel = i_reg_wr && (i_reg_addr == smc_pkg::ADDR_VSEL);
	assign wr_byp  = i_reg_wr && (i_reg_addr == smc_pkg::ADDR_BYP);
	// R3 R4 R22 read-only codes, zero when absent
	assign vsel_rd = SUPPORT_LV ? {LV_MIN_CODE, code_q} : 8'h00;
	assign byp_rd  = SUPPORT_BYPASS ? {BYP_CODE, 3'h0, byp_q} : 8'h00;
	assign rd_d    = (i_reg_addr == smc_pkg::ADDR_VSEL) ? vsel_rd :
		(i_reg_addr == smc_pkg::ADDR_BYP) ? byp_rd : 8'h00;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			// R1 R2 R5 fields clear at power-up
			code_q  <= smc_pkg::CODE_RST;
			byp_q   <= smc_pkg::BYP_RST;
			rdata_q <= 8'h00;
		end else begin
			// R2 R12 R24 only the code nibble is stored
			if (wr_vsel && SUPPORT_LV) begin
				code_q <= i_reg_wdata[3:0];
			end
			// R5 R24 only bit 0 is stored
			if (wr_byp && SUPPORT_BYPASS) begin
				byp_q <= i_reg_wdata[smc_pkg::BYP_EN_BIT];
			end
			if (i_reg_rd) begin
				rdata_q <= rd_d;
			end
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	// R19 voltage code wins over bypass
	assign mode_d = (SUPPORT_LV && code_q != 4'h0) ? smc_pkg::SMC_MODE_LV :
		(SUPPORT_BYPASS && byp_q) ? smc_pkg::SMC_MODE_BYPASS : smc_pkg::SMC_MODE_DEFAULT;

	// ****************************************
	// Threshold checker
	// ****************************************
	assign thr.code       = code_q;
	assign thr.byp_code   = BYP_CODE;
	assign thr.mode       = mode_q;
	assign thr.tol        = TOL_CNT;
	assign thr.meas       = i_vcc_meas;
	assign thr.meas_valid = i_vcc_meas_valid;

	smc_thr_check u_thr (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.thr   (thr.chk)
	);

	// ****************************************
	// Standby sequencer
	// ****************************************
	// Settle time lets the rail move before judging it
	assign settle_done = (settle_q == SETTLE_LAST);
	assign check_bad   = thr.below || thr.above;

	always_comb begin
		state_d = state_q;
		case (state_q)
			smc_pkg::SMC_ST_RUN: begin
				// R14 power-down enters standby
				if (pd_s2_q) begin
					state_d = smc_pkg::SMC_ST_STANDBY;
				end
			end
			smc_pkg::SMC_ST_STANDBY: begin
				if (!pd_s2_q) begin
					state_d = smc_pkg::SMC_ST_CHECK;
				end
			end
			smc_pkg::SMC_ST_CHECK: begin
				// R16 judge supply after settle
				if (pd_s2_q) begin
					state_d = smc_pkg::SMC_ST_STANDBY;
				end else if (settle_done) begin
					state_d = check_bad ? smc_pkg::SMC_ST_FAULT : smc_pkg::SMC_ST_RUN;
				end
			end
			smc_pkg::SMC_ST_FAULT: begin
				if (pd_s2_q) begin
					state_d = smc_pkg::SMC_ST_STANDBY;
				end
			end
			default: begin
				state_d = smc_pkg::SMC_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			// R1 default mode, running
			state_q  <= smc_pkg::SMC_ST_RUN;
			mode_q   <= smc_pkg::SMC_MODE_DEFAULT;
			settle_q <= '0;
		end else begin
			state_q  <= state_d;
			mode_q   <= mode_d;
			settle_q <= (state_q == smc_pkg::SMC_ST_CHECK && !settle_done) ?
				SMC_SW'(settle_q + 1'b1) : '0;
		end
	end

	// ****************************************
	// Supply flags
	// ****************************************
	// R9 out of range while running also flags
	assign run_bad_lo = (state_q == smc_pkg::SMC_ST_RUN) && thr.below;
	assign run_bad_hi = (state_q == smc_pkg::SMC_ST_RUN) && thr.above;
	assign set_lo     = ANY_OPT && (run_bad_lo ||
		(state_q == smc_pkg::SMC_ST_CHECK && settle_done && !pd_s2_q && thr.below));
	assign set_hi     = ANY_OPT && (run_bad_hi ||
		(state_q == smc_pkg::SMC_ST_CHECK && settle_done && !pd_s2_q && thr.above));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flag_lo_q <= 1'b0;
			flag_hi_q <= 1'b0;
			int_q     <= 1'b0;
			txd_q     <= 1'b0;
			nr_q      <= 1'b0;
		end else begin
			// R23 sticky, a set beats a clear
			flag_lo_q <= set_lo || (flag_lo_q && !i_flag_clr);
			flag_hi_q <= set_hi || (flag_hi_q && !i_flag_clr);
			// R9 interrupt follows latched flags
			int_q     <= set_lo || set_hi || ((flag_lo_q || flag_hi_q) && !i_flag_clr);
			// R14 transmitter off in standby
			txd_q     <= (state_d == smc_pkg::SMC_ST_STANDBY);
			// R16 not ready unless running
			nr_q      <= (state_d != smc_pkg::SMC_ST_RUN);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_reg_rdata        = rdata_q;
	// R20 R21 R22 capability bits
	assign o_cap_id           = (8'(ANY_OPT) << smc_pkg::CAP_VPS_BIT) | (8'(SUPPORT_LV) << smc_pkg::CAP_LV_BIT)
		| (8'(SUPPORT_BYPASS) << smc_pkg::CAP_BYP_BIT);
	assign o_mode             = mode_q;
	assign o_tx_disable       = txd_q;
	assign o_module_not_ready = nr_q;
	assign o_vcc_flag_lo      = flag_lo_q;
	assign o_vcc_flag_hi      = flag_hi_q;
	assign o_int              = int_q;
	assign o_thr_lo           = thr.thr_lo;
	assign o_thr_hi           = thr.thr_hi;

	// ****************************************
	// Assertions
	// ****************************************
	// R19 precedence check
	a_mode_code_wins: assert property (@(posedge i_clk) disable iff (i_rst) // R19
		(SUPPORT_LV && code_q != 4'h0) |=> (o_mode == smc_pkg::SMC_MODE_LV || $changed(code_q)))
		else $error("voltage code did not take precedence");

	// R2 code written lands in read path
	a_code_write_read: assert property (@(posedge i_clk) disable iff (i_rst) // R2
		(wr_vsel && SUPPORT_LV) |=> (code_q == $past(i_reg_wdata[3:0])))
		else $error("voltage code write lost");

	// R24 read-only nibble stable
	a_ro_nibble_fixed: assert property (@(posedge i_clk) disable iff (i_rst) // R24
		(i_reg_rd && i_reg_addr == smc_pkg::ADDR_VSEL) |=>
		(o_reg_rdata[7:4] == (SUPPORT_LV ? LV_MIN_CODE : 4'h0)))
		else $error("read-only nibble changed");

	// R5 reserved bits read zero
	a_byp_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst) // R5
		(i_reg_rd && i_reg_addr == smc_pkg::ADDR_BYP) |=> (o_reg_rdata[3:1] == 3'h0))
		else $error("reserved bits not zero");

	// R12 power-down keeps fields
	a_pd_keeps_code: assert property (@(posedge i_clk) disable iff (i_rst) // R12
		($fell(pd_s2_q) && !i_reg_wr) |=> $stable(code_q) && $stable(byp_q))
		else $error("power-down edge altered mode fields");

	// R14 transmitter disabled during standby
	a_tx_off_standby: assert property (@(posedge i_clk) disable iff (i_rst) // R14
		(state_q == smc_pkg::SMC_ST_STANDBY) |-> o_tx_disable)
		else $error("transmitter on in standby");

	// R16 bad check gives fault and not ready
	a_check_fault: assert property (@(posedge i_clk) disable iff (i_rst) // R16
		(state_q == smc_pkg::SMC_ST_CHECK && settle_done && !pd_s2_q && check_bad && ANY_OPT)
		|=> o_module_not_ready && (o_vcc_flag_lo || o_vcc_flag_hi) && o_int)
		else $error("failed supply check not reported");

	// R16 good check resumes
	a_check_resume: assert property (@(posedge i_clk) disable iff (i_rst) // R16
		(state_q == smc_pkg::SMC_ST_CHECK && settle_done && !pd_s2_q && !check_bad)
		|=> (state_q == smc_pkg::SMC_ST_RUN) && !o_module_not_ready)
		else $error("good supply did not resume");

	// R23 low flag holds without a clear
	a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_rst) // R23
		(o_vcc_flag_lo && !i_flag_clr) |=> o_vcc_flag_lo)
		else $error("supply flag dropped without clear");

	// R8 threshold follows mode
	a_thr_tracks_mode: assert property (@(posedge i_clk) disable iff (i_rst) // R8
		(mode_q == smc_pkg::SMC_MODE_LV && $stable(mode_q) && $stable(code_q)) |=>
		(o_thr_hi == 16'(smc_pkg::NOM_CNT - 16'($past(code_q)) * smc_pkg::STEP_CNT + TOL_CNT)))
		else $error("threshold not adjusted to mode");

	// R23 high flag holds without a clear
	a_flag_hi_sticky: assert property (@(posedge i_clk) disable iff (i_rst) // R23
		(o_vcc_flag_hi && !i_flag_clr) |=> o_vcc_flag_hi)
		else $error("high supply flag dropped without clear");

	// R9 interrupt mirrors latched flags
	a_int_follows_flags: assert property (@(posedge i_clk) disable iff (i_rst) // R9
		(o_vcc_flag_lo || o_vcc_flag_hi) |-> o_int)
		else $error("supply flag set without interrupt");

	// R16 not ready while in standby
	a_standby_not_ready: assert property (@(posedge i_clk) disable iff (i_rst) // R16
		(state_q == smc_pkg::SMC_ST_STANDBY) |-> o_module_not_ready)
		else $error("ready reported in standby");

	// R14 transmitter on while running
	a_run_tx_on: assert property (@(posedge i_clk) disable iff (i_rst) // R14
		(state_q == smc_pkg::SMC_ST_RUN) |-> !o_tx_disable)
		else $error("transmitter off while running");

	// R5 bypass enable write lands
	a_byp_write_read: assert property (@(posedge i_clk) disable iff (i_rst) // R5
		(wr_byp && SUPPORT_BYPASS) |=> (byp_q == $past(i_reg_wdata[smc_pkg::BYP_EN_BIT])))
		else $error("bypass enable write lost");

	// R19 bypass alone selects bypass mode
	a_mode_bypass_only: assert property (@(posedge i_clk) disable iff (i_rst) // R19
		(SUPPORT_BYPASS && byp_q && (code_q == 4'h0 || !SUPPORT_LV)) |=> (o_mode == smc_pkg::SMC_MODE_BYPASS))
		else $error("bypass mode not selected");

endmodule
`default_nettype wire

// [smc_host_model.sv]
// Host side model: management register port and power-down pin
`default_nettype none
module smc_host_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_reg_rdata,
	output logic            o_p_down,
	output logic      [7:0] o_reg_addr,
	output logic            o_reg_wr,
	output logic            o_reg_rd,
	output logic      [7:0] o_reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_p_down    = 1'b0;
		o_reg_addr  = 8'h00;
		o_reg_wr    = 1'b0;
		o_reg_rd    = 1'b0;
		o_reg_wdata = 8'h00;
	end
	// ****************************************
	// Register access
	// ****************************************
	// callers write mode fields in standby
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_reg_addr  = a;
		o_reg_wdata = d;
		o_reg_wr    = 1'b1;
		@(negedge i_clk);
		o_reg_wr    = 1'b0;
		// Stale data would hide a late capture
		o_reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_reg_addr = a;
		o_reg_rd   = 1'b1;
		@(negedge i_clk);
		o_reg_rd   = 1'b0;
		@(negedge i_clk);
		d = i_reg_rdata;
	endtask
	task automatic pdown(input logic lvl);
		@(negedge i_clk);
		o_p_down = lvl;
	endtask
endmodule
`default_nettype wire

// [tb.sv]
// Testbench for the core supply mode control block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] TOL = smc_pkg::TOL_CNT_RST;
	logic        i_clk;
	logic        i_rst;
	logic        p_down, reg_wr, reg_rd, flag_clr, meas_valid;
	logic        tx_dis, not_rdy, flag_lo, flag_hi, irq;
	logic [7:0]  reg_addr, reg_wdata, rdata, rdata_none, cap_id, cap_none, d;
	logic [15:0] meas, thr_lo, thr_hi;
	logic [1:0]  mode;
	int          err_count;
	int          tests_run;

	smc_host_model u_host (.i_clk(i_clk), .i_reg_rdata(rdata), .o_p_down(p_down), .o_reg_addr(reg_addr),
		.o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_wdata(reg_wdata));
	smc_supply_mode_control u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_p_down(p_down),
		.i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata),
		.i_vcc_meas(meas), .i_vcc_meas_valid(meas_valid), .i_flag_clr(flag_clr), .o_reg_rdata(rdata),
		.o_cap_id(cap_id), .o_mode(mode), .o_tx_disable(tx_dis), .o_module_not_ready(not_rdy),
		.o_vcc_flag_lo(flag_lo), .o_vcc_flag_hi(flag_hi), .o_int(irq), .o_thr_lo(thr_lo), .o_thr_hi(thr_hi));
	// No optional mode: everything must read zero
	smc_supply_mode_control #(.SUPPORT_LV(1'b0), .SUPPORT_BYPASS(1'b0)) u_none (.i_clk(i_clk), .i_rst(i_rst),
		.i_p_down(p_down), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata),
		.i_vcc_meas(meas), .i_vcc_meas_valid(meas_valid), .i_flag_clr(flag_clr), .o_reg_rdata(rdata_none),
		.o_cap_id(cap_none), .o_mode(), .o_tx_disable(), .o_module_not_ready(), .o_vcc_flag_lo(),
		.o_vcc_flag_hi(), .o_int(), .o_thr_lo(), .o_thr_hi());

	initial begin
		i_clk = 1'b0;
	end
	always #5 i_clk = ~i_clk;
	// Valid every other cycle, so unsampled measurements are exercised too
	always @(negedge i_clk) begin
		meas_valid <= i_rst || !meas_valid;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] nom(input logic [3:0] c);
		return smc_pkg::NOM_CNT - 16'(c) * smc_pkg::STEP_CNT;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
		u_host.rd(a, d);
		chk(16'(d), 16'(exp), msg);
	endtask
	task automatic thr_chk(input logic [15:0] n, input string msg);
		chk(thr_lo, n - TOL, msg);
		chk(thr_hi, n + TOL, msg);
	endtask
	// Clears flags, leaves standby, waits out the supply check
	task automatic leave();
		@(negedge i_clk);
		flag_clr = 1'b1;
		@(negedge i_clk);
		flag_clr = 1'b0;
		u_host.pdown(1'b0);
		wt(110);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		#200us;
		err_count++;
		report_and_stop();
	end
	initial begin
		err_count  = 0;
		tests_run  = 0;
		i_rst      = 1'b1;
		flag_clr   = 1'b0;
		meas       = smc_pkg::NOM_CNT;
		wt(5);
		i_rst = 1'b0;
		wt(2);
		chk(16'({mode, not_rdy, irq}), 16'h0, "reset state");
		thr_chk(nom(4'h0), "default thresholds");
		chk(16'(cap_id), 16'h98, "capability byte");
		rdc(8'h3a, 8'h30, "vsel reset");
		rdc(8'h3b, 8'h60, "bypass reset");
		rdc(8'h55, 8'h00, "unmapped read");
		u_host.pdown(1'b1);
		wt(4);
		chk(16'({tx_dis, not_rdy}), 16'h3, "standby outputs");
		u_host.wr(8'h3a, 8'hff);
		u_host.wr(8'h3b, 8'hff);
		rdc(8'h3a, 8'h3f, "vsel read-only nibble");
		rdc(8'h3b, 8'h61, "bypass reserved bits");
		chk(16'(mode), 16'h1, "code over bypass");
		thr_chk(nom(4'hf), "lv thresholds code f");
		u_host.wr(8'h3b, 8'h00);
		u_host.wr(8'h3a, 8'h05);
		wt(3);
		chk(16'(mode), 16'h1, "lv mode");
		thr_chk(nom(4'h5), "lv thresholds code 5");
		meas = nom(4'h5);
		leave();
		chk(16'({tx_dis, not_rdy, irq}), 16'h0, "run after lv entry");
		rdc(8'h3a, 8'h35, "code kept after release");
		meas = nom(4'h5) - TOL - 16'h1;
		wt(3);
		meas = nom(4'h5);
		wt(3);
		chk(16'({flag_lo, flag_hi, irq}), 16'h5, "low flag latched");
		meas = nom(4'h5) + TOL + 16'h1;
		wt(3);
		meas = nom(4'h5);
		wt(3);
		chk(16'({flag_lo, flag_hi, irq, not_rdy}), 16'he, "high flag latched");
		flag_clr = 1'b1;
		wt(1);
		flag_clr = 1'b0;
		wt(2);
		chk(16'({flag_lo, flag_hi, irq}), 16'h0, "flags cleared");
		u_host.pdown(1'b1);
		wt(4);
		u_host.wr(8'h3a, 8'h00);
		u_host.wr(8'h3b, 8'h01);
		wt(3);
		chk(16'(mode), 16'h2, "bypass mode");
		thr_chk(nom(4'h6), "bypass thresholds");
		meas = nom(4'h6);
		leave();
		chk(16'({tx_dis, not_rdy, irq}), 16'h0, "run after bypass");
		u_host.pdown(1'b1);
		wt(4);
		u_host.wr(8'h3b, 8'h00);
		wt(3);
		chk(16'(mode), 16'h0, "default mode back");
		thr_chk(nom(4'h0), "default thresholds back");
		// Supply left low on purpose, so the check must fail
		leave();
		chk(16'({not_rdy, flag_lo, irq}), 16'h7, "fault on bad supply");
		u_host.pdown(1'b1);
		meas = smc_pkg::NOM_CNT;
		wt(4);
		leave();
		chk(16'({tx_dis, not_rdy, flag_lo, irq}), 16'h0, "run after recovery");
		chk(16'(cap_none), 16'h0, "no capability bits");
		rdc(8'h3a, 8'h30, "main vsel back to zero code");
		chk(16'(rdata_none), 16'h0, "unsupported vsel");
		u_host.rd(8'h3b, d);
		chk(16'(rdata_none), 16'h0, "unsupported bypass");
		report_and_stop();
	end
endmodule
`default_nettype wire
